// ### hwm_core_model.sv
`timescale 1ns/1ns
module hwm_core_model (
  // clock and strobe
  input  wire logic      clk_i,
  input  wire logic      instr_cycle_i,
  // instruction fields
  output logic           mul_req_o,
  output hwm_pkg::hwm_byte_t work_o,
  output hwm_pkg::hwm_byte_t freg_o,
  output logic           hi_we_o,
  output logic           lo_we_o,
  output hwm_pkg::hwm_byte_t wdata_o,
  output logic           flags_we_o,
  output hwm_pkg::hwm_flags_t flags_o
);
  import hwm_pkg::*;
  initial begin
    {mul_req_o, hi_we_o, lo_we_o, flags_we_o} = 4'h0;
    {work_o, freg_o, wdata_o} = 24'h0;
    flags_o = 5'h00;
  end
  // working and file operands
  // hold fields until the strobe edge takes them
  task automatic issue(input logic m, input hwm_byte_t a, input hwm_byte_t b, input logic hw,
                       input logic lw, input hwm_byte_t d, input logic fw, input hwm_flags_t f);
    do begin
      @(posedge clk_i);
      mul_req_o  <= m;
      work_o     <= a;
      freg_o     <= b;
      hi_we_o    <= hw;
      lo_we_o    <= lw;
      wdata_o    <= d;
      flags_we_o <= fw;
      flags_o    <= f;
      @(negedge clk_i);
    end while (instr_cycle_i !== 1'b1);
    @(posedge clk_i);
    {mul_req_o, hi_we_o, lo_we_o, flags_we_o} <= 4'h0;
    work_o  <= ~a;
    freg_o  <= ~b;
    wdata_o <= ~d;
  endtask : issue
endmodule : hwm_core_model

// ### hwm_mult.sv
`timescale 1ns/1ns
module hwm_mult #(
  parameter int unsigned CLKS_PER_INSTR = hwm_pkg::HWM_CLKS_PER_INSTR
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // multiply instruction
  input  wire logic              mul_req_i,
  input  wire hwm_pkg::hwm_byte_t working_register_i,
  input  wire hwm_pkg::hwm_byte_t file_reg_i,
  // product register file access
  input  wire logic              prod_hi_we_i,
  input  wire logic              prod_lo_we_i,
  input  wire hwm_pkg::hwm_byte_t prod_wdata_i,
  // status flag updates from other alu operations
  input  wire logic              flags_we_i,
  input  wire hwm_pkg::hwm_flags_t flags_i,
  // instruction cycle strobe and results
  output logic                   instr_cycle_o,
  output logic                   mul_done_o,
  output hwm_pkg::hwm_byte_t     product_high_byte_o,
  output hwm_pkg::hwm_byte_t     product_low_byte_o,
  output hwm_pkg::hwm_flags_t    status_o
);
  import hwm_pkg::*;

  hwm_prod_if pif ();

  logic [7:0] div_reg;
  logic [7:0] div_next;
  logic       cyc_en;
  logic       mul_take;
  logic       done_reg;
  logic       done_next;
  hwm_flags_t flags_reg;
  hwm_flags_t flags_next;

  function automatic hwm_prod_t hwm_umul(input hwm_byte_t a, input hwm_byte_t b);
    hwm_prod_t wa;
    hwm_prod_t wb;
    wa = {{HWM_OPND_W{1'b0}}, a};
    wb = {{HWM_OPND_W{1'b0}}, b};
    return hwm_prod_t'(wa * wb);
  endfunction : hwm_umul

  // instruction cycle divider
  always_comb begin
    if (div_reg == 8'(CLKS_PER_INSTR - 1)) begin
      div_next = HWM_DIV_RST;
    end else begin
      div_next = div_reg + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_reg <= HWM_DIV_RST;
    end else begin
      div_reg <= div_next;
    end
  end

  assign cyc_en        = (div_reg == 8'(CLKS_PER_INSTR - 1));
  assign instr_cycle_o = cyc_en;
  assign mul_take      = cyc_en & mul_req_i;

  // operands from working and file registers
  assign pif.load     = mul_take;
  assign pif.load_val = hwm_umul(working_register_i, file_reg_i);
  // writes land on the instruction strobe
  assign pif.hi_we    = cyc_en & prod_hi_we_i;
  assign pif.lo_we    = cyc_en & prod_lo_we_i;
  assign pif.wdata    = prod_wdata_i;

  hwm_prod_regs u_prod (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .pif   (pif.regs)
  );

  assign product_high_byte_o = pif.prod_hi;
  assign product_low_byte_o  = pif.prod_lo;

  // status flags and completion pulse
  always_comb begin
    flags_next = flags_reg;
    if (cyc_en && flags_we_i && !mul_req_i) begin
      flags_next = flags_i;
    end
    // done pulses one clock after the strobe that takes the multiply
    done_next = mul_take;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_reg <= HWM_FLAGS_RST;
      done_reg  <= 1'b0;
    end else begin
      flags_reg <= flags_next;
      done_reg  <= done_next;
    end
  end

  assign status_o   = flags_reg;
  assign mul_done_o = done_reg;

  // check helper: clocks since the last instruction strobe
  logic [7:0] gap_reg;
  logic [7:0] gap_next;

  always_comb begin
    if (cyc_en) begin
      gap_next = HWM_DIV_RST;
    end else begin
      gap_next = gap_reg + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gap_reg <= HWM_DIV_RST;
    end else begin
      gap_reg <= gap_next;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_full_product: assert property (
    mul_take |=> {product_high_byte_o, product_low_byte_o} ==
      ({8'h00, $past(working_register_i)} * {8'h00, $past(file_reg_i)}))
    else $error("product not the full unsigned product");

  a_high_byte_place: assert property (
    mul_take |=> product_high_byte_o == 8'(($past(working_register_i) *
      16'($past(file_reg_i))) >> 8))
    else $error("high product byte wrong");

  a_low_byte_place: assert property (
    mul_take |=> product_low_byte_o == 8'($past(working_register_i) * $past(file_reg_i)))
    else $error("low product byte wrong");

  a_flags_untouched: assert property (
    mul_take |=> $stable(status_o))
    else $error("multiply changed status flags");

  a_one_cycle_done: assert property (
    mul_take |=> mul_done_o ##1 !mul_done_o)
    else $error("multiply done pulse late or stretched");

  a_done_has_cause: assert property (
    mul_done_o |-> $past(mul_take))
    else $error("done without a multiply");

  a_operand_source: assert property (
    mul_take && working_register_i == 8'h00 |=>
      product_high_byte_o == 8'h00 && product_low_byte_o == 8'h00)
    else $error("product not from working register operand");

  a_product_holds: assert property (
    !mul_take && !pif.hi_we && !pif.lo_we |=>
      $stable(product_high_byte_o) && $stable(product_low_byte_o))
    else $error("product changed without cause");

  a_sw_write_hi: assert property (
    pif.hi_we && !mul_take |=> product_high_byte_o == $past(prod_wdata_i))
    else $error("software write to high byte lost");

  a_sw_write_lo: assert property (
    pif.lo_we && !mul_take |=> product_low_byte_o == $past(prod_wdata_i))
    else $error("software write to low byte lost");

  a_hi_kept_lo_write: assert property (
    pif.lo_we && !pif.hi_we && !mul_take |=> $stable(product_high_byte_o))
    else $error("low byte write disturbed high byte");

  a_lo_kept_hi_write: assert property (
    pif.hi_we && !pif.lo_we && !mul_take |=> $stable(product_low_byte_o))
    else $error("high byte write disturbed low byte");

  a_flag_write_lands: assert property (
    cyc_en && flags_we_i && !mul_req_i |=> status_o == $past(flags_i))
    else $error("flag update from other operation lost");

  a_flags_hold_idle: assert property (
    !(cyc_en && flags_we_i) |=> $stable(status_o))
    else $error("status flags changed without an update");

  a_off_strobe_refused: assert property (
    mul_req_i && !cyc_en |=> !mul_done_o)
    else $error("multiply taken off the instruction strobe");

  a_strobe_period: assert property (
    cyc_en |-> gap_reg == 8'(CLKS_PER_INSTR - 1))
    else $error("instruction strobe period wrong");

  a_strobe_spacing: assert property (
    cyc_en |=> !cyc_en)
    else $error("instruction strobe on adjacent clocks");

  c_mul_max: cover property (
    mul_take && working_register_i == 8'hff && file_reg_i == 8'hff);
  c_mul_zero: cover property (
    mul_take && file_reg_i == 8'h00);
  c_write_then_mul: cover property (
    pif.lo_we ##[1:8] mul_take);
  c_mul_back_to_back: cover property (
    mul_take ##[1:8] mul_take);
  c_flag_blocked: cover property (
    mul_take && flags_we_i);

endmodule : hwm_mult

// ### hwm_pkg.sv
package hwm_pkg;

  // operand and product widths
  localparam int unsigned HWM_OPND_W     = 8;
  localparam int unsigned HWM_PROD_W     = 2 * HWM_OPND_W;

  // product register reset values
  localparam logic [7:0]  HWM_PROD_HI_RST = 8'h00;
  localparam logic [7:0]  HWM_PROD_LO_RST = 8'h00;

  // arithmetic status flags: positions and reset value
  localparam int unsigned HWM_FLAGS_W    = 5;
  localparam int unsigned HWM_FLAG_C     = 0;
  localparam int unsigned HWM_FLAG_DC    = 1;
  localparam int unsigned HWM_FLAG_Z     = 2;
  localparam int unsigned HWM_FLAG_OV    = 3;
  localparam int unsigned HWM_FLAG_N     = 4;
  localparam logic [4:0]  HWM_FLAGS_RST  = 5'h00;

  // instruction cycle timing
  localparam int unsigned HWM_CLK_NS         = 50;
  localparam int unsigned HWM_INSTR_CYCLE_NS = 200;
  localparam int unsigned HWM_CLKS_PER_INSTR = (HWM_INSTR_CYCLE_NS + HWM_CLK_NS - 1) / HWM_CLK_NS;
  localparam logic [7:0]  HWM_DIV_RST        = 8'h00;

  typedef logic [HWM_OPND_W-1:0]  hwm_byte_t;
  typedef logic [HWM_PROD_W-1:0]  hwm_prod_t;
  typedef logic [HWM_FLAGS_W-1:0] hwm_flags_t;

endpackage : hwm_pkg

// ### hwm_prod_if.sv
`timescale 1ns/1ns
interface hwm_prod_if;
  import hwm_pkg::*;
  logic      load;
  hwm_prod_t load_val;
  logic      hi_we;
  logic      lo_we;
  hwm_byte_t wdata;
  hwm_byte_t prod_hi;
  hwm_byte_t prod_lo;

  modport ctrl (output load, output load_val, output hi_we, output lo_we, output wdata,
                input prod_hi, input prod_lo);
  modport regs (input load, input load_val, input hi_we, input lo_we, input wdata,
                output prod_hi, output prod_lo);
endinterface : hwm_prod_if

// ### hwm_prod_regs.sv
`timescale 1ns/1ns
module hwm_prod_regs (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // product register access
  hwm_prod_if.regs  pif
);
  import hwm_pkg::*;

  hwm_byte_t hi_reg;
  hwm_byte_t hi_next;
  hwm_byte_t lo_reg;
  hwm_byte_t lo_next;

  always_comb begin
    hi_next = hi_reg;
    lo_next = lo_reg;
    if (pif.load) begin
      hi_next = pif.load_val[HWM_PROD_W-1:HWM_OPND_W];
      lo_next = pif.load_val[HWM_OPND_W-1:0];
    end else begin
      if (pif.hi_we) begin
        hi_next = pif.wdata;
      end
      if (pif.lo_we) begin
        lo_next = pif.wdata;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hi_reg <= HWM_PROD_HI_RST;
      lo_reg <= HWM_PROD_LO_RST;
    end else begin
      hi_reg <= hi_next;
      lo_reg <= lo_next;
    end
  end

  assign pif.prod_hi = hi_reg;
  assign pif.prod_lo = lo_reg;

endmodule : hwm_prod_regs

// ### testbench.sv
`timescale 1ns/1ns
module testbench;
  import hwm_pkg::*;
  logic       clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       req, hwe, lwe, fwe, strobe, done;
  hwm_byte_t  work, freg, wd, hi, lo;
  hwm_flags_t fl, st;
  int         errors = 0;
  int         checked = 0;
  int         cycles = 0;

  always #25 clk_i = ~clk_i;

  hwm_core_model hwm_core_model_i (
    .clk_i(clk_i), .instr_cycle_i(strobe), .mul_req_o(req), .work_o(work), .freg_o(freg),
    .hi_we_o(hwe), .lo_we_o(lwe), .wdata_o(wd), .flags_we_o(fwe), .flags_o(fl));

  hwm_mult #(.CLKS_PER_INSTR(4)) hwm_mult_i (
    .clk_i(clk_i), .rst_i(rst_i), .mul_req_i(req), .working_register_i(work),
    .file_reg_i(freg), .prod_hi_we_i(hwe), .prod_lo_we_i(lwe), .prod_wdata_i(wd),
    .flags_we_i(fwe), .flags_i(fl), .instr_cycle_o(strobe), .mul_done_o(done),
    .product_high_byte_o(hi), .product_low_byte_o(lo), .status_o(st));

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic final_report;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  // products over corner operands, back to back
  task automatic t_mul;
    hwm_byte_t a[6] = '{8'h00, 8'hff, 8'h80, 8'h0f, 8'h01, 8'hff};
    hwm_byte_t b[6] = '{8'h00, 8'hff, 8'h02, 8'h10, 8'hff, 8'h01};
    #1;
    cmp({hi, lo}, 16'h0000);
    cmp(16'(st), 16'h0000);
    hwm_core_model_i.issue(1'b0, 8'h00, 8'h00, 1'b0, 1'b0, 8'h00, 1'b1, 5'h1f);
    #1;
    cmp(16'(st), 16'h001f);
    for (int i = 0; i < 6; i++) begin
      hwm_core_model_i.issue(1'b1, a[i], b[i], 1'b0, 1'b0, 8'h00, 1'b0, 5'h00);
      #1;
      cmp({hi, lo}, 16'(a[i]) * 16'(b[i]));
      cmp(16'(done), 16'h0001);
      cmp(16'(st), 16'h001f);
    end
    @(posedge clk_i);
    #1;
    cmp(16'(done), 16'h0000);
  endtask : t_mul

  // software writes, holding, multiply beats write
  task automatic t_hold;
    hwm_core_model_i.issue(1'b0, 8'h00, 8'h00, 1'b1, 1'b1, 8'h5a, 1'b0, 5'h00);
    #1;
    cmp({hi, lo}, 16'h5a5a);
    cmp(16'(done), 16'h0000);
    hwm_core_model_i.issue(1'b0, 8'h00, 8'h00, 1'b1, 1'b0, 8'hc3, 1'b0, 5'h00);
    repeat (7) @(posedge clk_i);
    #1;
    cmp({hi, lo}, 16'hc35a);
    hwm_core_model_i.issue(1'b0, 8'h00, 8'h00, 1'b0, 1'b1, 8'h69, 1'b0, 5'h00);
    #1;
    cmp({hi, lo}, 16'hc369);
    hwm_core_model_i.issue(1'b1, 8'h12, 8'h34, 1'b1, 1'b1, 8'hee, 1'b0, 5'h00);
    #1;
    cmp({hi, lo}, 16'h03a8);
  endtask : t_hold

  // flag write blocked during a multiply
  task automatic t_flags;
    hwm_core_model_i.issue(1'b1, 8'h02, 8'h03, 1'b0, 1'b0, 8'h00, 1'b1, 5'h0a);
    #1;
    cmp(16'(st), 16'h001f);
    cmp({hi, lo}, 16'h0006);
    hwm_core_model_i.issue(1'b0, 8'h00, 8'h00, 1'b0, 1'b0, 8'h00, 1'b1, 5'h0a);
    #1;
    cmp(16'(st), 16'h000a);
    cmp({hi, lo}, 16'h0006);
  endtask : t_flags

  // mid-run reset clears products, flags and the strobe phase
  task automatic t_reset;
    int n = 0;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    cmp({hi, lo}, 16'h0000);
    cmp(16'(st), 16'h0000);
    cmp(16'(done), 16'h0000);
    while (strobe !== 1'b1 && n < 16) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    cmp(16'(n), 16'(HWM_CLKS_PER_INSTR - 1));
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (strobe !== 1'b1 && n < 16);
    cmp(16'(n), 16'(HWM_CLKS_PER_INSTR));
  endtask : t_reset

  // signed 8x8 built by software: sign fix-ups on the high byte
  task automatic t_signed;
    hwm_byte_t a[3] = '{8'h80, 8'hff, 8'h7f};
    hwm_byte_t b[3] = '{8'h80, 8'h02, 8'h81};
    for (int i = 0; i < 3; i++) begin
      hwm_core_model_i.issue(1'b1, a[i], b[i], 1'b0, 1'b0, 8'h00, 1'b0, 5'h00);
      #1;
      // subtract other operand per sign bit
      if (b[i][7]) begin
        hwm_core_model_i.issue(1'b0, 8'h00, 8'h00, 1'b1, 1'b0, hi - a[i], 1'b0, 5'h00);
        #1;
      end
      if (a[i][7]) begin
        hwm_core_model_i.issue(1'b0, 8'h00, 8'h00, 1'b1, 1'b0, hi - b[i], 1'b0, 5'h00);
        #1;
      end
      cmp({hi, lo}, 16'(int'($signed(a[i])) * int'($signed(b[i]))));
    end
  endtask : t_signed

  // 16x16 unsigned from four weighted partial products
  task automatic t_wide;
    hwm_byte_t   xa[4] = '{8'hdc, 8'hfe, 8'hdc, 8'hfe};
    hwm_byte_t   yb[4] = '{8'h98, 8'hba, 8'hba, 8'h98};
    int          sh[4] = '{0, 16, 8, 8};
    logic [31:0] res   = 32'h0;
    logic [31:0] want  = 32'hfedc * 32'hba98;
    for (int i = 0; i < 4; i++) begin
      hwm_core_model_i.issue(1'b1, xa[i], yb[i], 1'b0, 1'b0, 8'h00, 1'b0, 5'h00);
      #1;
      // weight partial products by byte shift
      res = res + ({16'h0000, hi, lo} << sh[i]);
    end
    cmp(res[31:16], want[31:16]);
    cmp(res[15:0], want[15:0]);
  endtask : t_wide

  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 3000) begin
      errors++;
      final_report();
    end
  end

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_mul();
    t_hold();
    t_flags();
    t_reset();
    t_signed();
    t_wide();
    final_report();
  end
endmodule : testbench
